// ### src/port_power_status_flags.v
// status flag bank of a usb port power controller
// assumes events and analog comparator levels arrive synchronous to mclk_i
//
// Function
// - overcurrent sets fault bit 0, alert, error
// - overcurrent flag clears on read or master
// - master flag cleared by zero write, power off
// - master flag need not mirror alert pin
// - quota done sets bit 7, optional alert
// - quota flag clears on restart or disable
// - bit 4 follows above-limit level
// - thermal throttle sets bit 3, linked alert
// - low charge current sets bit 2
// - removal sets bit 1, releases attach pin
// - attach sets bit 0, asserts attach pin
// - profile flags never drive alert pins
// - profile flags except undervoltage clear on power, mode, removal
// - no handshake only in dedicated cycle
// - no handshake never set in a cycle an accept, apply or clear arrives
// - undervoltage holds switch off, sets bit 4
// - custom handshake sets bit 3, custom settings
// - dedicated accept sets bit 2, constant limit
// - downstream handshake sets bit 1, trip limit
// - passthrough mode sets bit 0, trip limit
// - passthrough flag rearmed only by mode toggle
// - legacy flags seven..one at bits 6..0
// - alert is active low open drain
// - zero write rechecks errors before active
`timescale 1ns/100ps
`include "port_status_defines.vh"
module port_power_status_flags #(
    parameter LEGACY_COUNT = 7
) (
    input wire mclk_i,
    input wire rst_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // control state from the configuration side
    input wire port_power_enable_i,
    input wire auto_recovery_i,
    input wire [1:0] quota_behaviour_select_i,
    input wire quota_restart_i,
    input wire quota_enable_i,
    input wire alert_link_i,
    input wire mode_select_one_i,
    input wire passthrough_mode_i,
    input wire new_mode_i,
    input wire dedicated_cycle_switch_ctl_i,
    input wire custom_switch_close_i,
    input wire custom_trip_limit_i,
    input wire [LEGACY_COUNT-1:0] legacy_trip_limit_i,
    // analog and sequencer events
    input wire above_limit_i,
    input wire above_region_two_minimum_i,
    input wire other_error_i,
    input wire quota_reached_i,
    input wire thermal_throttle_i,
    input wire charge_current_low_i,
    input wire removal_event_i,
    input wire attach_event_i,
    input wire dedicated_emulation_cycle_i,
    input wire profile_applied_i,
    input wire profile_no_handshake_i,
    input wire custom_profile_ok_i,
    input wire dedicated_profile_ok_i,
    input wire downstream_profile_ok_i,
    input wire [LEGACY_COUNT-1:0] legacy_accept_i,
    input wire source_undervoltage_i,
    // pins and port controls
    output reg alert_o,
    output reg alert_oe_o,
    output reg attach_detect_out_n_o,
    output reg attach_detect_oe_o,
    output reg port_switch_on_o,
    output reg data_switch_close_o,
    output reg trip_limit_o,
    output reg [1:0] power_state_o
);

    // ------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------
    wire rd_fault = reg_rd_i && (reg_addr_i == `ADDR_FAULT_STATUS);
    wire rd_gen = reg_rd_i && (reg_addr_i == `ADDR_GENERAL_STATUS);
    wire wr_fault = reg_wr_i && (reg_addr_i == `ADDR_FAULT_STATUS);
    wire master_zero_wr = wr_fault && !reg_wdata_i[`FLT_MASTER];

    // ------------------------------------------------------------
    // fault flags and power state
    // ------------------------------------------------------------
    reg overcurrent_fault_q;
    reg master_error_q;
    reg error_state_q;
    reg port_power_enable_q;
    wire overcurrent_now = above_limit_i && above_region_two_minimum_i;
    wire any_error_now = overcurrent_now || other_error_i;
    wire power_disable = port_power_enable_q && !port_power_enable_i;
    // master clears: host zero write, auto recovery, or power disable
    wire master_clear = (master_zero_wr && !any_error_now)
        || (auto_recovery_i && !any_error_now)
        || power_disable;
    wire master_set = any_error_now && !(power_disable);

    always @(posedge mclk_i) begin
        if (rst_i) begin
            overcurrent_fault_q <= 1'b0;
            master_error_q <= 1'b0;
            error_state_q <= 1'b0;
            port_power_enable_q <= 1'b0;
        end else begin
            port_power_enable_q <= port_power_enable_i;
            // set wins over any clear in the same cycle, except that power disable beats the master set
            if (overcurrent_now) begin
                overcurrent_fault_q <= 1'b1;
            end else if (rd_fault || master_clear) begin
                overcurrent_fault_q <= 1'b0;
            end
            if (master_set) begin
                master_error_q <= 1'b1;
                error_state_q <= 1'b1;
            end else if (master_clear) begin
                master_error_q <= 1'b0;
                error_state_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // general status flags
    // ------------------------------------------------------------
    reg quota_done_q;
    reg region_two_q;
    reg thermal_throttle_q;
    reg current_low_q;
    reg removal_seen_q;
    reg attach_seen_q;
    reg attached_q;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            quota_done_q <= 1'b0;
            region_two_q <= 1'b0;
            thermal_throttle_q <= 1'b0;
            current_low_q <= 1'b0;
            removal_seen_q <= 1'b0;
            attach_seen_q <= 1'b0;
            attached_q <= 1'b0;
        end else begin
            // quota restart/disable beats the event: the run is void
            if (quota_restart_i || !quota_enable_i) begin
                quota_done_q <= 1'b0;
            end else if (quota_reached_i) begin
                quota_done_q <= 1'b1;
            end else if (rd_gen) begin
                quota_done_q <= 1'b0;
            end
            region_two_q <= above_limit_i;
            if (thermal_throttle_i) begin
                thermal_throttle_q <= 1'b1;
            end else if (rd_gen) begin
                thermal_throttle_q <= 1'b0;
            end
            if (charge_current_low_i) begin
                current_low_q <= 1'b1;
            end else if (rd_gen) begin
                current_low_q <= 1'b0;
            end
            if (removal_event_i) begin
                removal_seen_q <= 1'b1;
            end else if (rd_gen) begin
                removal_seen_q <= 1'b0;
            end
            if (attach_event_i) begin
                attach_seen_q <= 1'b1;
            end else if (rd_gen) begin
                attach_seen_q <= 1'b0;
            end
            if (attach_event_i) begin
                attached_q <= 1'b1;
            end else if (removal_event_i) begin
                attached_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // charge profile flags
    // ------------------------------------------------------------
    // one shared clear for every accepted-profile indicator
    wire profile_clear = power_disable || new_mode_i
        || removal_event_i;
    reg custom_ok_q;
    reg dedicated_ok_q;
    reg downstream_ok_q;
    reg passthrough_q;
    reg passthrough_armed_q;
    reg no_handshake_q;
    reg undervolt_q;
    reg mode_one_q;
    wire mode_one_toggle = mode_one_q != mode_select_one_i;
    wire any_accept = custom_profile_ok_i || dedicated_profile_ok_i
        || downstream_profile_ok_i || (|legacy_accept_i);

    always @(posedge mclk_i) begin
        if (rst_i) begin
            custom_ok_q <= 1'b0;
            dedicated_ok_q <= 1'b0;
            downstream_ok_q <= 1'b0;
            passthrough_q <= 1'b0;
            passthrough_armed_q <= 1'b1;
            no_handshake_q <= 1'b0;
            undervolt_q <= 1'b0;
            mode_one_q <= 1'b0;
        end else begin
            mode_one_q <= mode_select_one_i;
            undervolt_q <= source_undervoltage_i;
            if (profile_clear) begin
                custom_ok_q <= 1'b0;
                dedicated_ok_q <= 1'b0;
                downstream_ok_q <= 1'b0;
            end else begin
                if (custom_profile_ok_i && dedicated_emulation_cycle_i) begin
                    custom_ok_q <= 1'b1;
                end
                if (dedicated_profile_ok_i) begin
                    dedicated_ok_q <= 1'b1;
                end
                if (downstream_profile_ok_i) begin
                    downstream_ok_q <= 1'b1;
                end
            end
            // removal disarms; only a mode-one toggle rearms
            if (mode_one_toggle) begin
                passthrough_armed_q <= 1'b1;
            end else if (removal_event_i) begin
                passthrough_armed_q <= 1'b0;
            end
            if (profile_clear) begin
                passthrough_q <= 1'b0;
            end else if (passthrough_mode_i && passthrough_armed_q) begin
                passthrough_q <= 1'b1;
            end
            // a miss is only flagged when no accept, apply or clear comes with it
            if (profile_applied_i || any_accept || profile_clear) begin
                no_handshake_q <= 1'b0;
            end else if (profile_no_handshake_i
                    && dedicated_emulation_cycle_i) begin
                no_handshake_q <= 1'b1;
            end
        end
    end

    wire [LEGACY_COUNT-1:0] legacy_ok;
    legacy_profile_flags #(
        .COUNT(LEGACY_COUNT)
    ) u_legacy (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clear_i(profile_clear),
        .accept_i(legacy_accept_i),
        .flags_o(legacy_ok)
    );

    // ------------------------------------------------------------
    // register images and read data
    // ------------------------------------------------------------
    wire [7:0] fault_image = {master_error_q, 6'h00,
        overcurrent_fault_q};
    wire [7:0] gen_image = {quota_done_q, 2'h0, region_two_q,
        thermal_throttle_q, current_low_q, removal_seen_q,
        attach_seen_q};
    wire [7:0] prof_image = {no_handshake_q, 2'h0, undervolt_q,
        custom_ok_q, dedicated_ok_q, downstream_ok_q, passthrough_q};
    wire [7:0] legacy_image = {1'b0, legacy_ok};
    reg [7:0] rdata_d;

    always @* begin
        case (reg_addr_i)
            `ADDR_FAULT_STATUS: rdata_d = fault_image;
            `ADDR_GENERAL_STATUS: rdata_d = gen_image;
            `ADDR_CHARGE_PROFILE: rdata_d = prof_image;
            `ADDR_LEGACY_PROFILE: rdata_d = legacy_image;
            default: rdata_d = `STATUS_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // pins and switch control
    // ------------------------------------------------------------
    // alert comes from flag contents and the outside error input, not the master bit alone,
    // so it can move while the master bit stands still
    wire alert_d = overcurrent_fault_q
        || (quota_done_q
            && quota_behaviour_select_i == `QUOTA_BEH_ALERT)
        || (alert_link_i && (thermal_throttle_q || current_low_q))
        || other_error_i;
    // profile flags deliberately absent from both pin terms
    reg data_close_d;
    reg trip_d;

    always @* begin
        data_close_d = 1'b0;
        trip_d = 1'b1;
        if (passthrough_mode_i || downstream_ok_q) begin
            data_close_d = 1'b1;
            trip_d = 1'b1;
        end else if (dedicated_ok_q) begin
            data_close_d = dedicated_cycle_switch_ctl_i;
            trip_d = 1'b0;
        end else if (custom_ok_q) begin
            data_close_d = custom_switch_close_i;
            trip_d = custom_trip_limit_i;
        end else if (|legacy_ok) begin
            data_close_d = dedicated_cycle_switch_ctl_i;
            trip_d = |(legacy_ok & legacy_trip_limit_i);
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= `STATUS_RESET;
            alert_o <= 1'b0;
            alert_oe_o <= 1'b0;
            attach_detect_out_n_o <= 1'b0;
            attach_detect_oe_o <= 1'b0;
            port_switch_on_o <= 1'b0;
            data_switch_close_o <= 1'b0;
            trip_limit_o <= 1'b1;
            power_state_o <= `PST_ACTIVE;
        end else begin
            reg_rdata_o <= rdata_d;
            alert_o <= 1'b0;
            alert_oe_o <= alert_d;
            attach_detect_out_n_o <= 1'b0;
            attach_detect_oe_o <= attach_event_i
                || (attached_q && !removal_event_i);
            port_switch_on_o <= port_power_enable_i && !error_state_q
                && !source_undervoltage_i;
            data_switch_close_o <= data_close_d;
            trip_limit_o <= trip_d;
            power_state_o <= (master_set || error_state_q)
                ? `PST_ERROR : `PST_ACTIVE;
        end
    end

endmodule // port_power_status_flags

// ### src/port_status_defines.vh
// register map and field layout of the port power status flags
// assumes byte-wide registers reached over an 8-bit register port
`ifndef PORT_STATUS_DEFINES_VH
`define PORT_STATUS_DEFINES_VH

`define ADDR_FAULT_STATUS 8'h10
`define ADDR_GENERAL_STATUS 8'h11
`define ADDR_CHARGE_PROFILE 8'h12
`define ADDR_LEGACY_PROFILE 8'h13

// fault_status fields
`define FLT_OVERCURRENT 0
`define FLT_MASTER 7
// general_status fields
`define GEN_ATTACH 0
`define GEN_REMOVAL 1
`define GEN_CURRENT_LOW 2
`define GEN_THERMAL 3
`define GEN_REGION_TWO 4
`define GEN_QUOTA_DONE 7
// charge_profile_status fields
`define PRF_PASSTHROUGH 0
`define PRF_DOWNSTREAM 1
`define PRF_DEDICATED 2
`define PRF_CUSTOM 3
`define PRF_UNDERVOLT 4
`define PRF_NO_HANDSHAKE 7

`define STATUS_RESET 8'h00
// quota behaviour code that selects a host interrupt
`define QUOTA_BEH_ALERT 2'h1

// power states
`define PST_ACTIVE 2'h2
`define PST_ERROR 2'h3

`endif

// ### src/legacy_profile_flags.v
// accepted-profile flags for the legacy charger profiles
// assumes one-cycle accept strobes from the emulation sequencer
`timescale 1ns/100ps
module legacy_profile_flags #(
    parameter COUNT = 7
) (
    input wire mclk_i,
    input wire rst_i,
    input wire clear_i,
    input wire [COUNT-1:0] accept_i,
    output wire [COUNT-1:0] flags_o
);
    genvar g;
    generate
        for (g = 0; g < COUNT; g = g + 1) begin : g_flag
            // one flop per profile, so each bit has a single driver
            reg flag_q;
            always @(posedge mclk_i) begin
                if (rst_i) begin
                    flag_q <= 1'b0;
                end else if (clear_i) begin
                    flag_q <= 1'b0;
                end else if (accept_i[g]) begin
                    flag_q <= 1'b1;
                end
            end
            assign flags_o[g] = flag_q;
        end
    endgenerate
endmodule // legacy_profile_flags

// ### tb/port_power_status_flags_checker.sv
// timing checks on the status flag bank pins and register port
// assumes one clock, synchronous active-high reset, bound to the top
`timescale 1ns/100ps
module port_power_status_flags_checker (
    input wire mclk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire port_power_enable_i,
    input wire quota_enable_i,
    input wire quota_restart_i,
    input wire [1:0] quota_behaviour_select_i,
    input wire alert_link_i,
    input wire above_limit_i,
    input wire above_region_two_minimum_i,
    input wire quota_reached_i,
    input wire thermal_throttle_i,
    input wire attach_event_i,
    input wire removal_event_i,
    input wire downstream_profile_ok_i,
    input wire source_undervoltage_i,
    input wire alert_oe_o,
    input wire attach_detect_oe_o,
    input wire port_switch_on_o,
    input wire data_switch_close_o,
    input wire trip_limit_o,
    input wire [1:0] power_state_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire oc = above_limit_i && above_region_two_minimum_i;
    // ----
    // properties
    // ----
    property p_oc;
        oc && port_power_enable_i |-> ##[1:3] alert_oe_o && power_state_o == 2'h3;
    endproperty
    a_oc: assert property (p_oc) else $error("no error on overcurrent");
    // flag image lags the level by one stage, so the level must be steady
    property p_region;
        reg_rd_i && reg_addr_i == 8'h11 && $stable(above_limit_i) && !$past(rst_i)
            |=> reg_rdata_o[4] == $past(above_limit_i);
    endproperty
    a_region: assert property (p_region) else $error("region bit wrong");
    property p_unmapped;
        reg_addr_i < 8'h10 || reg_addr_i > 8'h13 |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    property p_attach;
        attach_event_i && !removal_event_i |-> ##[1:3] attach_detect_oe_o;
    endproperty
    a_attach: assert property (p_attach) else $error("attach pin idle");
    property p_remove;
        removal_event_i && !attach_event_i |-> ##[1:3] !attach_detect_oe_o;
    endproperty
    a_remove: assert property (p_remove) else $error("attach pin held");
    property p_thermal;
        thermal_throttle_i && alert_link_i |-> ##[1:3] alert_oe_o;
    endproperty
    a_thermal: assert property (p_thermal) else $error("linked alert missing");
    property p_quota;
        quota_reached_i && quota_enable_i && !quota_restart_i
            && quota_behaviour_select_i == 2'h1 |-> ##[1:3] alert_oe_o;
    endproperty
    a_quota: assert property (p_quota) else $error("quota alert missing");
    property p_cdp;
        downstream_profile_ok_i && port_power_enable_i
            |-> ##[1:3] data_switch_close_o && trip_limit_o;
    endproperty
    a_cdp: assert property (p_cdp) else $error("downstream setup wrong");
    property p_uv;
        source_undervoltage_i |-> ##[1:2] !port_switch_on_o;
    endproperty
    a_uv: assert property (p_uv) else $error("switch on in undervoltage");
    c_attach: cover property (attach_event_i ##3 attach_detect_oe_o);
    c_oc: cover property (oc && port_power_enable_i);
    c_cdp: cover property (downstream_profile_ok_i);
endmodule // port_power_status_flags_checker

bind port_power_status_flags port_power_status_flags_checker chk (.*);

// ### tb/portable_device.sv
// portable device on the charging port: attach, removal, handshakes
// assumes the bench calls pulse from its main sequence
`timescale 1ns/100ps
module portable_device (
    input wire mclk_i,
    output reg [12:0] ev_o
);
    initial ev_o = 13'h0000;
    // one event vector per call, held for one cycle, whatever bits it mixes
    task pulse(input [12:0] v);
        begin
            @(negedge mclk_i) ev_o = v;
            @(negedge mclk_i) ev_o = 13'h0000;
        end
    endtask
endmodule // portable_device

// ### tb/port_power_status_flags_tb_top.sv
// self-checking bench of the status flag bank against a register model
// assumes the portable device model and the bound checker
`timescale 1ns/100ps
module port_power_status_flags_tb_top;
    reg mclk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [7:0] addr = 8'h00;
    reg rd_s = 1'b0;
    reg wr_s = 1'b0;
    reg [7:0] wdata = 8'h00;
    reg [15:0] lv = 16'h0000;
    reg [1:0] qb = 2'h0;
    reg hsw = 1'b1;
    reg csw = 1'b0;
    reg ctrip = 1'b0;
    reg oerr = 1'b0;
    reg [6:0] ltrip = 7'h00;
    reg [1:0] ex;
    wire [12:0] ev;
    wire [7:0] rdata;
    wire alert, alert_oe, adet_n, adet_oe, psw, dsw, trip;
    wire [1:0] pst;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int m[4];
    int i;
    int v;
    always #2 mclk_i = ~mclk_i;
    portable_device dev (.mclk_i(mclk_i), .ev_o(ev));
    port_power_status_flags #(.LEGACY_COUNT(7)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .port_power_enable_i(lv[0]),
        .auto_recovery_i(lv[1]), .quota_behaviour_select_i(qb),
        .quota_restart_i(lv[2]), .quota_enable_i(lv[3]),
        .alert_link_i(lv[4]), .mode_select_one_i(lv[5]),
        .passthrough_mode_i(lv[6]), .new_mode_i(lv[7]),
        .dedicated_cycle_switch_ctl_i(hsw), .custom_switch_close_i(csw),
        .custom_trip_limit_i(ctrip), .legacy_trip_limit_i(ltrip),
        .above_limit_i(lv[8]), .above_region_two_minimum_i(lv[9]),
        .other_error_i(oerr), .quota_reached_i(lv[10]),
        .thermal_throttle_i(lv[11]), .charge_current_low_i(lv[12]),
        .removal_event_i(ev[1]), .attach_event_i(ev[0]),
        .dedicated_emulation_cycle_i(lv[13]), .profile_applied_i(lv[14]),
        .profile_no_handshake_i(ev[5]), .custom_profile_ok_i(ev[4]),
        .dedicated_profile_ok_i(ev[3]), .downstream_profile_ok_i(ev[2]),
        .legacy_accept_i(ev[12:6]), .source_undervoltage_i(lv[15]),
        .alert_o(alert), .alert_oe_o(alert_oe),
        .attach_detect_out_n_o(adet_n), .attach_detect_oe_o(adet_oe),
        .port_switch_on_o(psw), .data_switch_close_o(dsw),
        .trip_limit_o(trip), .power_state_o(pst));
    // ----
    // tasks
    // ----
    task chk(input [7:0] g, input [7:0] e);
        begin
            check_count++;
            if (g !== e) begin
                num_errors++;
                $display("FAIL t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_pin(input g, input e);
        chk({7'h00, g}, {7'h00, e});
    endtask
    task tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task pl(input int n);
        begin
            @(negedge mclk_i) lv[n] = 1'b1;
            @(negedge mclk_i) lv[n] = 1'b0;
        end
    endtask
    // model keeps only the level bit of general status after a read
    task rd_reg(input [7:0] a);
        begin
            @(negedge mclk_i) addr = a;
            rd_s = 1'b1;
            @(negedge mclk_i) rd_s = 1'b0;
            chk(rdata, (a > 8'h0F && a < 8'h14) ? m[a - 8'h10][7:0] : 8'h00);
            if (a == 8'h11) m[1] = m[1] & 8'h10;
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(negedge mclk_i) addr = a;
            wdata = d;
            wr_s = 1'b1;
            @(negedge mclk_i) wr_s = 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            if (num_errors == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // whole run is a few hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop;
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        v = $urandom(32'hdeac7d83);
        v = $urandom;
        {hsw, csw, ctrip, ltrip} = v[9:0];
        tick(8);
        rst_i = 1'b0;
        for (i = 15; i < 21; i++) rd_reg(i[7:0]);
        wr_reg(8'h11, 8'hFF);
        rd_reg(8'h11);
        lv[0] = 1'b1;
        tick(3);
        chk_pin(psw, 1'b1);
        dev.pulse(13'h0001);
        tick(3);
        m[1] = 1;
        chk_pin(adet_oe, 1'b1);
        chk_pin(alert_oe, 1'b0);
        rd_reg(8'h11);
        fork
            rd_reg(8'h11);
            dev.pulse(13'h0001);
        join
        m[1] = 1;
        tick(2);
        rd_reg(8'h11);
        dev.pulse(13'h0002);
        tick(3);
        m[1] = 2;
        chk_pin(adet_oe, 1'b0);
        rd_reg(8'h11);
        pl(12);
        tick(3);
        m[1] = 4;
        chk_pin(alert_oe, 1'b0);
        rd_reg(8'h11);
        lv[4] = 1'b1;
        pl(11);
        tick(3);
        m[1] = 8;
        chk_pin(alert_oe, 1'b1);
        rd_reg(8'h11);
        lv[8] = 1'b1;
        tick(3);
        m[1] = 8'h10;
        rd_reg(8'h11);
        lv[9] = 1'b1;
        tick(4);
        m[0] = 8'h81;
        chk({6'h00, pst}, 8'h03);
        wr_reg(8'h10, 8'h00);
        tick(2);
        rd_reg(8'h10);
        lv[9:8] = 2'b00;
        m[1] = 0;
        tick(2);
        rd_reg(8'h11);
        rd_reg(8'h10);
        m[0] = 8'h80;
        rd_reg(8'h10);
        wr_reg(8'h10, 8'h00);
        m[0] = 0;
        tick(3);
        rd_reg(8'h10);
        chk({6'h00, pst}, 8'h02);
        lv[9:8] = 2'b11;
        tick(4);
        lv[9:8] = 2'b00;
        tick(2);
        lv[0] = 1'b0;
        tick(3);
        rd_reg(8'h10);
        lv[0] = 1'b1;
        qb = 2'h1;
        lv[3] = 1'b1;
        pl(10);
        tick(3);
        m[1] = 8'h80;
        rd_reg(8'h11);
        pl(10);
        tick(2);
        lv[3] = 1'b0;
        tick(2);
        rd_reg(8'h11);
        lv[3] = 1'b1;
        pl(10);
        tick(2);
        pl(2);
        tick(2);
        rd_reg(8'h11);
        for (i = 0; i < 3; i++) begin
            // custom handshake only counts inside the dedicated cycle
            lv[13] = (i == 2);
            dev.pulse(13'h0004 << i);
            tick(3);
            m[2] = 2 << i;
            ex = {i == 0 || (i == 2 && ctrip), i == 0 || (i == 1 ? hsw : csw)};
            chk_pin(trip, ex[1]);
            chk_pin(dsw, ex[0]);
            chk_pin(alert_oe | adet_oe, 1'b0);
            rd_reg(8'h12);
            pl(7);
            tick(3);
            m[2] = 0;
            rd_reg(8'h12);
        end
        v = $urandom % 127 + 1;
        dev.pulse({v[6:0], 6'h00});
        tick(3);
        m[3] = v;
        rd_reg(8'h13);
        chk_pin(trip, |(v[6:0] & ltrip));
        chk_pin(dsw, hsw);
        dev.pulse(13'h0002);
        tick(3);
        m[3] = 0;
        m[1] = 2;
        rd_reg(8'h13);
        rd_reg(8'h11);
        lv[5] = 1'b1;
        tick(2);
        lv[6] = 1'b1;
        tick(3);
        m[2] = 1;
        chk_pin(trip, 1'b1);
        rd_reg(8'h12);
        dev.pulse(13'h0002);
        tick(2);
        dev.pulse(13'h0001);
        tick(3);
        m[2] = 0;
        m[1] = 3;
        rd_reg(8'h12);
        rd_reg(8'h11);
        lv[5] = 1'b0;
        tick(3);
        m[2] = 1;
        rd_reg(8'h12);
        lv[6] = 1'b0;
        pl(7);
        tick(3);
        m[2] = 0;
        rd_reg(8'h12);
        lv[13] = 1'b1;
        dev.pulse(13'h0020);
        tick(3);
        m[2] = 8'h80;
        rd_reg(8'h12);
        pl(14);
        tick(3);
        m[2] = 0;
        rd_reg(8'h12);
        lv[13] = 1'b0;
        dev.pulse(13'h0020);
        tick(3);
        rd_reg(8'h12);
        lv[15] = 1'b1;
        tick(3);
        m[2] = 8'h10;
        chk_pin(psw, 1'b0);
        rd_reg(8'h12);
        lv[15] = 1'b0;
        tick(3);
        m[2] = 0;
        rd_reg(8'h12);
        // outside error: alert follows it, master flag stays latched
        oerr = 1'b1;
        tick(3);
        m[0] = 8'h80;
        chk_pin(alert_oe, 1'b1);
        oerr = 1'b0;
        tick(3);
        chk_pin(alert_oe, 1'b0);
        rd_reg(8'h10);
        lv[1] = 1'b1;
        tick(3);
        m[0] = 0;
        rd_reg(8'h10);
        chk({6'h00, pst}, 8'h02);
        chk_pin(alert, 1'b0);
        chk_pin(adet_n, 1'b0);
        report_and_stop;
    end
endmodule // port_power_status_flags_tb_top
